// File: cba_consts.svh
// Register offsets, field positions and reset values of the circular buffer block
`ifndef CBA_CONSTS_SVH
`define CBA_CONSTS_SVH
`define CBA_OFF_CONTROL 12'h000
`define CBA_OFF_X_START 12'h004
`define CBA_OFF_X_END 12'h008
`define CBA_OFF_Y_START 12'h00c
`define CBA_OFF_Y_END 12'h010
`define CBA_OFF_STATUS 12'h014
`define CBA_XSEL_LSB 0
`define CBA_XSEL_MSB 3
`define CBA_YSEL_LSB 4
`define CBA_YSEL_MSB 7
`define CBA_YEN_BIT 14
`define CBA_XEN_BIT 15
`define CBA_SEL_NONE 4'hf
`define CBA_RST_CONTROL 16'h00ff
`define CBA_RST_ADDR 16'h0000
`endif

// File: cba_pkg.sv
// Types shared by the circular buffer addressing block
`default_nettype none
package cba_pkg;
	typedef struct packed {
		logic valid;
		logic [3:0] wreg;
		logic [15:0] cur;
		logic [15:0] nxt;
	} cba_upd_t;
	typedef struct packed {
		logic [15:0] addr;
		logic wrapped;
	} cba_res_t;
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} cba_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cba_apb_rsp_t;
endpackage : cba_pkg
`default_nettype wire

// File: cba_wrap.sv
// Boundary check and wrap of one pointer update against a buffer
`timescale 1ns/100ps
`default_nettype none
module cba_wrap (
	// Configuration
	input wire logic active_in,
	input wire logic word_in,
	input wire logic [15:0] start_in,
	input wire logic [15:0] end_in,
	// Update
	input wire logic [15:0] cur_in,
	input wire logic [15:0] nxt_in,
	output logic [15:0] addr_out,
	output logic wrapped_out
);
	logic [15:0] lo;
	logic [15:0] hi;
	logic [15:0] cur;
	logic [15:0] nxt;
	logic up;
	always_comb begin
		// Word-sized view clears the address bit zero
		lo = word_in ? {start_in[15:1], 1'b0} : start_in;
		hi = word_in ? {end_in[15:1], 1'b0} : end_in;
		cur = word_in ? {cur_in[15:1], 1'b0} : cur_in;
		nxt = word_in ? {nxt_in[15:1], 1'b0} : nxt_in;
		up = nxt > cur;
		addr_out = nxt;
		wrapped_out = 1'b0;
		if (active_in) begin
			if (up && nxt > hi && cur <= hi) begin
				addr_out = lo;
				wrapped_out = 1'b1;
			end else if (!up && nxt < lo && cur >= lo) begin
				addr_out = hi;
				wrapped_out = 1'b1;
			end
		end
	end
endmodule : cba_wrap
`default_nettype wire

// File: cba_apb.sv
// APB slave front end that turns a transfer into a one-cycle strobe
`timescale 1ns/100ps
`default_nettype none
module cba_apb (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Bus
	input wire cba_pkg::cba_apb_req_t req_in,
	output cba_pkg::cba_apb_rsp_t rsp_out,
	// Register side
	input wire logic [31:0] rdata_in,
	input wire logic hit_in,
	output logic wr_out,
	output logic rd_out
);
	import cba_pkg::*;
	typedef struct packed {
		logic [31:0] prdata;
		logic pslverr;
		logic done;
	} cba_apb_st_t;
	cba_apb_st_t st_reg;
	cba_apb_st_t st_next;
	logic access;
	assign access = req_in.psel && req_in.penable && !st_reg.done;
	// Write lands at the edge that completes the transfer, while pready is high
	assign wr_out = ce_in && req_in.psel && req_in.penable && st_reg.done && req_in.pwrite
		&& hit_in;
	assign rd_out = ce_in && access && !req_in.pwrite;
	assign rsp_out.pready = st_reg.done;
	assign rsp_out.prdata = st_reg.prdata;
	assign rsp_out.pslverr = st_reg.pslverr;
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (access) begin
			st_next.done = 1'b1;
			st_next.pslverr = !hit_in;
			st_next.prdata = (!req_in.pwrite && hit_in) ? rdata_in : 32'h00000000;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end
endmodule : cba_apb
`default_nettype wire

// File: cba_top.sv
// Circular buffer address generation for the X and Y spaces with APB registers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cba_consts.svh"
// Notes on behaviour
// - One circular buffer in X space, one in Y; X also serves program space.
// - Wrap logic is identical for data and program space pointers.
// - Power-of-two buffers are checked at both bounds, either direction.
// - Four 16-bit loadable start and end address registers.
// - Y space wrap treats address bit zero as clear.
// - Length follows from end minus start; up to 32K words.
// - Bits 3:0 pick the X pointer; 1111 disables X read and write wrap.
// - X wrap needs select not 1111 and enable bit 15 set.
// - Bits 7:4 pick the Y pointer; 1111 disables Y wrap.
// - Y wrap needs select not 1111 and enable bit 14 set.
module cba_top (
	// Clock, reset and enable
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	// APB register bus
	input wire cba_pkg::cba_apb_req_t APB_REQ_IN,
	output cba_pkg::cba_apb_rsp_t APB_RSP_OUT,
	// X read, X write and Y pointer updates
	input wire cba_pkg::cba_upd_t XRD_UPD_IN,
	input wire cba_pkg::cba_upd_t XWR_UPD_IN,
	input wire cba_pkg::cba_upd_t Y_UPD_IN,
	// Resulting addresses
	output cba_pkg::cba_res_t XRD_RES_OUT,
	output cba_pkg::cba_res_t XWR_RES_OUT,
	output cba_pkg::cba_res_t Y_RES_OUT,
	// Decoded enables
	output logic X_ACTIVE_OUT,
	output logic Y_ACTIVE_OUT
);
	import cba_pkg::*;
	localparam int NCH = 3;
	typedef struct packed {
		logic [15:0] control;
		logic [15:0] x_start;
		logic [15:0] x_end;
		logic [15:0] y_start;
		logic [15:0] y_end;
		logic [2:0] wrap_seen;
		cba_res_t [NCH-1:0] res;
	} cba_st_t;
	cba_st_t st_reg;
	cba_st_t st_next;
	logic wr;
	logic rd;
	logic hit;
	logic [31:0] rdata;
	logic x_active;
	logic y_active;
	cba_upd_t [NCH-1:0] upd;
	logic [NCH-1:0] ch_active;
	logic [NCH-1:0] ch_word;
	logic [NCH-1:0][15:0] ch_lo;
	logic [NCH-1:0][15:0] ch_hi;
	logic [NCH-1:0][15:0] w_addr;
	logic [NCH-1:0] w_wrap;
	logic [15:0] wd;

	// ==============================================================
	// Register bus
	cba_apb u_apb (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.req_in(APB_REQ_IN),
		.rsp_out(APB_RSP_OUT),
		.rdata_in(rdata),
		.hit_in(hit),
		.wr_out(wr),
		.rd_out(rd)
	);
	assign wd = APB_REQ_IN.pwdata[15:0];
	always_comb begin
		hit = 1'b1;
		rdata = 32'h00000000;
		case (APB_REQ_IN.paddr)
			`CBA_OFF_CONTROL: rdata = {16'h0000, st_reg.control};
			`CBA_OFF_X_START: rdata = {16'h0000, st_reg.x_start};
			`CBA_OFF_X_END: rdata = {16'h0000, st_reg.x_end};
			`CBA_OFF_Y_START: rdata = {16'h0000, st_reg.y_start};
			`CBA_OFF_Y_END: rdata = {16'h0000, st_reg.y_end};
			`CBA_OFF_STATUS: rdata = {27'h0000000, y_active, x_active, st_reg.wrap_seen};
			default: hit = 1'b0;
		endcase
	end

	// ==============================================================
	// Space enables
	always_comb begin
		x_active = (st_reg.control[`CBA_XSEL_MSB:`CBA_XSEL_LSB] != `CBA_SEL_NONE)
			&& st_reg.control[`CBA_XEN_BIT];
		y_active = (st_reg.control[`CBA_YSEL_MSB:`CBA_YSEL_LSB] != `CBA_SEL_NONE)
			&& st_reg.control[`CBA_YEN_BIT];
	end
	assign X_ACTIVE_OUT = x_active;
	assign Y_ACTIVE_OUT = y_active;

	// ==============================================================
	// Per-generator wrap
	assign upd[0] = XRD_UPD_IN;
	assign upd[1] = XWR_UPD_IN;
	assign upd[2] = Y_UPD_IN;
	// Single X buffer shared by X read and write, one Y buffer
	assign ch_lo[0] = st_reg.x_start;
	assign ch_hi[0] = st_reg.x_end;
	assign ch_lo[1] = st_reg.x_start;
	assign ch_hi[1] = st_reg.x_end;
	assign ch_lo[2] = st_reg.y_start;
	assign ch_hi[2] = st_reg.y_end;
	assign ch_word = 3'b100;
	assign ch_active[0] = x_active
		&& upd[0].wreg == st_reg.control[`CBA_XSEL_MSB:`CBA_XSEL_LSB];
	assign ch_active[1] = x_active
		&& upd[1].wreg == st_reg.control[`CBA_XSEL_MSB:`CBA_XSEL_LSB];
	assign ch_active[2] = y_active
		&& upd[2].wreg == st_reg.control[`CBA_YSEL_MSB:`CBA_YSEL_LSB];
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			// Same bidirectional check for every pointer
			cba_wrap u_wrap (
				.active_in(ch_active[g]),
				.word_in(ch_word[g]),
				.start_in(ch_lo[g]),
				.end_in(ch_hi[g]),
				.cur_in(upd[g].cur),
				.nxt_in(upd[g].nxt),
				.addr_out(w_addr[g]),
				.wrapped_out(w_wrap[g])
			);
		end
	endgenerate

	// ==============================================================
	// State update
	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < NCH; i++) begin
			if (upd[i].valid) begin
				st_next.res[i].addr = w_addr[i];
				st_next.res[i].wrapped = w_wrap[i];
			end else begin
				st_next.res[i].wrapped = 1'b0;
			end
		end
		// Reading status clears the wrap history, a new wrap wins
		if (rd && APB_REQ_IN.paddr == `CBA_OFF_STATUS) begin
			st_next.wrap_seen = 3'b000;
		end
		for (int i = 0; i < NCH; i++) begin
			if (upd[i].valid && w_wrap[i]) begin
				st_next.wrap_seen[i] = 1'b1;
			end
		end
		if (wr) begin
			case (APB_REQ_IN.paddr)
				`CBA_OFF_CONTROL: st_next.control = wd;
				`CBA_OFF_X_START: st_next.x_start = wd;
				`CBA_OFF_X_END: st_next.x_end = wd;
				`CBA_OFF_Y_START: st_next.y_start = wd;
				`CBA_OFF_Y_END: st_next.y_end = wd;
				default: st_next.control = st_reg.control;
			endcase
		end
	end
	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			st_reg <= '0;
			st_reg.control <= `CBA_RST_CONTROL;
			st_reg.x_start <= `CBA_RST_ADDR;
			st_reg.x_end <= `CBA_RST_ADDR;
			st_reg.y_start <= `CBA_RST_ADDR;
			st_reg.y_end <= `CBA_RST_ADDR;
		end else if (CE_IN) begin
			st_reg <= st_next;
		end
	end
	assign XRD_RES_OUT = st_reg.res[0];
	assign XWR_RES_OUT = st_reg.res[1];
	assign Y_RES_OUT = st_reg.res[2];
endmodule : cba_top
`default_nettype wire

// File: cba_top_assertions.sv
// Port checker for the circular buffer block
`timescale 1ns/100ps
`default_nettype none
module cba_top_checker (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	// Bus and pointer updates
	input wire cba_pkg::cba_apb_req_t APB_REQ_IN,
	input wire cba_pkg::cba_apb_rsp_t APB_RSP_OUT,
	input wire cba_pkg::cba_upd_t XRD_UPD_IN,
	input wire cba_pkg::cba_upd_t XWR_UPD_IN,
	input wire cba_pkg::cba_upd_t Y_UPD_IN,
	// Results
	input wire cba_pkg::cba_res_t XRD_RES_OUT,
	input wire cba_pkg::cba_res_t XWR_RES_OUT,
	input wire cba_pkg::cba_res_t Y_RES_OUT,
	input wire logic X_ACTIVE_OUT,
	input wire logic Y_ACTIVE_OUT
);
	import cba_pkg::*;
	// ====
	// Properties
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_apb_take;
		APB_REQ_IN.psel && APB_REQ_IN.penable && CE_IN && !APB_RSP_OUT.pready;
	endsequence
	sequence s_xrd_plain;
		XRD_UPD_IN.valid && CE_IN && !X_ACTIVE_OUT;
	endsequence
	a_apb_one_wait: assert property (s_apb_take |=> APB_RSP_OUT.pready)
		else $error("pready late");
	a_ready_pulse: assert property (APB_RSP_OUT.pready |=> !APB_RSP_OUT.pready)
		else $error("pready not a pulse");
	a_xrd_plain: assert property (s_xrd_plain |=> !XRD_RES_OUT.wrapped
		&& XRD_RES_OUT.addr == $past(XRD_UPD_IN.nxt)) else $error("x read wrapped");
	a_xwr_plain: assert property (XWR_UPD_IN.valid && CE_IN && !X_ACTIVE_OUT
		|=> XWR_RES_OUT.addr == $past(XWR_UPD_IN.nxt)) else $error("x write wrapped");
	a_y_plain: assert property (Y_UPD_IN.valid && CE_IN && !Y_ACTIVE_OUT |=>
		!Y_RES_OUT.wrapped && Y_RES_OUT.addr[15:1] == $past(Y_UPD_IN.nxt[15:1]))
		else $error("y wrapped");
	a_y_word: assert property (Y_UPD_IN.valid && CE_IN && Y_ACTIVE_OUT
		|=> !Y_RES_OUT.addr[0]) else $error("y odd");
	a_wrap_pulse: assert property (CE_IN && !XRD_UPD_IN.valid
		|=> !XRD_RES_OUT.wrapped) else $error("wrap stuck");
	a_addr_holds: assert property (CE_IN && !XWR_UPD_IN.valid
		|=> $stable(XWR_RES_OUT.addr)) else $error("addr moved");
endmodule : cba_top_checker
bind cba_top cba_top_checker cba_top_checker_i (.*);
`default_nettype wire

// File: cba_agu_model.sv
// Pointer update source standing in for the core address generators
`timescale 1ns/100ps
`default_nettype none
module cba_agu_model (
	// Clock
	input wire logic clk_in,
	// Updates
	output cba_pkg::cba_upd_t xrd_out,
	output cba_pkg::cba_upd_t xwr_out,
	output cba_pkg::cba_upd_t y_out
);
	import cba_pkg::*;
	cba_upd_t u [3] = '{default: '0};
	assign xrd_out = u[0];
	assign xwr_out = u[1];
	assign y_out = u[2];
	task automatic issue(input int p, input logic [3:0] w, input logic [15:0] c, n, input int d);
		repeat (d + 1) @(posedge clk_in);
		u[p] <= '{1'b1, w, c, n};
		@(posedge clk_in);
		u[p] <= '{1'b0, ~w, ~c, ~n};
	endtask : issue
endmodule : cba_agu_model
`default_nettype wire

// File: cba_tb_top.sv
// Self-checking bench for the circular buffer block
`timescale 1ns/100ps
`default_nettype none
`include "cba_consts.svh"
module cba_tb_top;
	import cba_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic err;
	logic [31:0] rd;
	cba_apb_req_t req = '0;
	cba_apb_rsp_t rsp;
	cba_upd_t xrd, xwr, yu;
	cba_res_t res [3];
	logic xact, yact;
	logic [17:0] tbl [5] = '{{16'h80ff, 2'b00}, {16'h0003, 2'b00}, {16'hc0f3, 2'b10},
		{16'h4053, 2'b01}, {16'hc053, 2'b11}};
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	initial forever #4 mclk = ~mclk;
	cba_top cba_top_i (.MCLK_IN(mclk), .RST_IN(rst), .CE_IN(ce), .APB_REQ_IN(req),
		.APB_RSP_OUT(rsp), .XRD_UPD_IN(xrd), .XWR_UPD_IN(xwr), .Y_UPD_IN(yu),
		.XRD_RES_OUT(res[0]), .XWR_RES_OUT(res[1]), .Y_RES_OUT(res[2]),
		.X_ACTIVE_OUT(xact), .Y_ACTIVE_OUT(yact));
	cba_agu_model cba_agu_model_i (.clk_in(mclk), .xrd_out(xrd), .xwr_out(xwr), .y_out(yu));
	// ====
	// Tasks
	task automatic tally_and_finish();
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do @(posedge mclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '{~a, 1'b0, 1'b0, ~w, ~d};
	endtask : apb
	task automatic tu(input int p, input logic [3:0] w, input logic [15:0] c, n, e,
		input logic ew);
		cba_agu_model_i.issue(p, w, c, n, p);
		#1;
		chk("addr", 32'(res[p].addr), 32'(e));
		chk("wrap", 32'(res[p].wrapped), 32'(ew));
	endtask : tu
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ====
	// Sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, `CBA_OFF_CONTROL, 0);
		chk("ctl", rd, 32'h0000_00ff);
		apb(1'b0, `CBA_OFF_X_END, 0);
		chk("xend", rd, 32'h0);
		apb(1'b1, `CBA_OFF_X_START, 32'hffff_1000);
		apb(1'b1, `CBA_OFF_X_END, 32'h0000_101e);
		apb(1'b1, `CBA_OFF_Y_START, 32'h0000_2001);
		apb(1'b1, `CBA_OFF_Y_END, 32'h0000_201f);
		apb(1'b0, `CBA_OFF_X_START, 0);
		chk("xstart", rd, 32'h0000_1000);
		apb(1'b0, `CBA_OFF_Y_END, 0);
		chk("yend", rd, 32'h0000_201f);
		apb(1'b0, 12'h020, 0);
		chk("slverr", 32'(err), 32'h1);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `CBA_OFF_CONTROL, 32'(tbl[i][17:2]));
			@(negedge mclk);
			chk("xact", 32'(xact), 32'(tbl[i][1]));
			chk("yact", 32'(yact), 32'(tbl[i][0]));
		end
		// Pointers 3 and 5 keep clear of the frame and stack pointers
		tu(0, 4'h3, 16'h101e, 16'h1020, 16'h1000, 1'b1);
		tu(1, 4'h3, 16'h1000, 16'h0ffe, 16'h101e, 1'b1);
		tu(0, 4'h4, 16'h101e, 16'h1020, 16'h1020, 1'b0);
		tu(0, 4'h3, 16'h1008, 16'h100a, 16'h100a, 1'b0);
		tu(2, 4'h5, 16'h201e, 16'h2020, 16'h2000, 1'b1);
		tu(2, 4'h5, 16'h2001, 16'h1fff, 16'h201e, 1'b1);
		apb(1'b0, `CBA_OFF_STATUS, 0);
		chk("status", rd, 32'h0000_001f);
		apb(1'b0, `CBA_OFF_STATUS, 0);
		chk("stclr", rd, 32'h0000_0018);
		apb(1'b1, `CBA_OFF_CONTROL, 32'h0000_4053);
		tu(1, 4'h3, 16'h101e, 16'h1020, 16'h1020, 1'b0);
		tu(2, 4'h5, 16'h201e, 16'h2020, 16'h2000, 1'b1);
		tu(0, 4'h3, 16'h101e, 16'h1020, 16'h1020, 1'b0);
		apb(1'b1, `CBA_OFF_CONTROL, 32'h0000_40f3);
		tu(2, 4'hf, 16'h201e, 16'h2020, 16'h2020, 1'b0);
		// Clock enable low freezes the result registers
		@(posedge mclk);
		ce <= 1'b0;
		tu(0, 4'h3, 16'h1010, 16'h1012, 16'h1020, 1'b0);
		@(posedge mclk);
		ce <= 1'b1;
		tally_and_finish();
	end
endmodule : cba_tb_top
`default_nettype wire
